// ---- hw/brk_pkg.sv ----
/*
  constants shared by the breakpoint unit: register indices, control and
  status field layout, fixed reserved bits, access type and length codes.
  assumes the core addresses debug registers by a small register index.
*/
package brk_pkg;
  localparam int          NUM_BP        = 4;
  // register indices as used by the register-move port
  localparam logic [2:0]  IDX_ADDR_LAST = 3'h3;
  localparam logic [2:0]  IDX_STATUS    = 3'h6;
  localparam logic [2:0]  IDX_CONTROL   = 3'h7;
  // control register layout
  localparam int          CTL_FIELD_LSB = 16;
  localparam int          CTL_FIELD_W   = 4;
  localparam int          CTL_LEN_OFS   = 2;
  localparam int          CTL_SUB_W     = 2;
  localparam int          CTL_EN_W      = 2;
  localparam int          CTL_G_OFS     = 1;
  localparam int          CTL_GD_BIT    = 13;
  localparam logic [31:0] CTL_FIXED_ONE = 32'h0000_0400;
  localparam logic [31:0] CTL_WRITABLE  = 32'hFFFF_20FF;
  localparam logic [31:0] CTL_RESET     = 32'h0000_0400;
  // status register layout
  localparam int          ST_BT_BIT     = 15;
  localparam int          ST_BS_BIT     = 14;
  localparam logic [31:0] ST_FIXED_ONE  = 32'h0000_1FF0;
  // address register reset value
  localparam logic [31:0] ADDR_RESET    = 32'h0000_0000;
  // access type codes
  localparam logic [1:0]  TYPE_EXEC     = 2'h0;
  localparam logic [1:0]  TYPE_WRITE    = 2'h1;
  localparam logic [1:0]  TYPE_RW       = 2'h3;
  // length codes
  localparam logic [1:0]  LEN_1         = 2'h0;
  localparam logic [1:0]  LEN_2         = 2'h1;
  localparam logic [1:0]  LEN_4         = 2'h3;
  // highest byte offset covered by each length
  localparam logic [1:0]  SPAN_1        = 2'h0;
  localparam logic [1:0]  SPAN_2        = 2'h1;
  localparam logic [1:0]  SPAN_4        = 2'h3;
  // most privileged level
  localparam logic [1:0]  PRIV_TOP      = 2'h0;
  // kind of memory access seen by the comparators
  typedef enum logic [1:0] {ACC_EXEC, ACC_READ, ACC_WRITE} acc_kind_t;
endpackage

// ---- hw/breakpoint_debug_unit.sv ----
/*
  breakpoint unit: four linear address comparators qualified by a control
  register, a sticky status register, and a register-move port.
  assumes the core presents each fetch or data access for one cycle and
  holds a fetched instruction until the exception output has been seen.
  match flags are captured only in a cycle that raises an exception, so a
  disabled breakpoint leaves its trace only beside some other cause.
  every exception drops the access-disable bit; a debugger relying on it
  must set it again before it returns.
  the status register clears only on the core's clear pulse or reset.
*/
//
// Contract
// RULE_01: four independent breakpoint linear address registers
// RULE_02: armed matching access raises debug exception
// RULE_03: breakpoint covers 1, 2 or 4 bytes
// RULE_04: register access only at level 0 or real
// RULE_05: per-breakpoint enable, type and length fields
// RULE_06: length/type pairs fill control bits 31..16
// RULE_07: type selects execution or data breakpoints
// RULE_08: execution break raised before instruction executes
// RULE_09: status register read-only, reports break causes
// RULE_10: status layout: BT15, BS14, matches 3..0
// RULE_11: fixed reserved bits ignore software writes
// RULE_12: type codes exec 00, write 01, rw 11
// RULE_13: length codes 1 byte 00, 2 01, 4 11
// RULE_14: task switch clears locals; exception clears disable
// RULE_15: match flags set even when disabled, sticky; the code sets them only in a cycle that raises a debug exception
// RULE_16: compare ignores low bits covered by length
`timescale 1ns/1ns
module breakpoint_debug_unit (
  // clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  // register-move port from the core
  input  wire logic              reg_req_in,
  input  wire logic              reg_write_in,
  input  wire logic [2:0]        reg_index_in,
  input  wire logic [31:0]       reg_wdata_in,
  input  wire logic [1:0]        priv_level_in,
  input  wire logic              real_mode_in,
  output logic                   reg_ack_out,
  output logic                   reg_fault_out,
  output logic                   reg_trap_out,
  output logic [31:0]            reg_rdata_out,
  // memory access monitor
  input  wire logic              acc_valid_in,
  input  wire brk_pkg::acc_kind_t acc_kind_in,
  input  wire logic [31:0]       acc_addr_in,
  input  wire logic [1:0]        acc_len_in,
  // core events
  input  wire logic              task_switch_in,
  input  wire logic              task_trap_in,
  input  wire logic              single_step_in,
  input  wire logic              status_clear_in,
  // exception toward the pipeline
  output logic                   debug_exc_out
);

  typedef struct packed {
    logic [brk_pkg::NUM_BP-1:0][31:0] bp_addr;
    logic [31:0]                      ctl;
    logic [brk_pkg::NUM_BP-1:0]       match_flag;
    logic                             task_switch_flag;
    logic                             single_step_flag;
    logic [31:0]                      rdata;
    logic                             ack;
    logic                             fault;
    logic                             trap;
    logic                             exc;
  } state_t;

  state_t cur;
  state_t next_cur;

  // highest byte offset covered by a length code; unused code spans one byte
  function automatic logic [1:0] len_span(input logic [1:0] code);
    case (code)
      brk_pkg::LEN_2: len_span = brk_pkg::SPAN_2;
      brk_pkg::LEN_4: len_span = brk_pkg::SPAN_4;
      default:        len_span = brk_pkg::SPAN_1;
    endcase
  endfunction

  // true when the access kind is one the type code watches
  function automatic logic type_ok(input logic [1:0] code,
                                   input brk_pkg::acc_kind_t kind);
    case (code)
      brk_pkg::TYPE_EXEC:  type_ok = (kind == brk_pkg::ACC_EXEC);
      brk_pkg::TYPE_WRITE: type_ok = (kind == brk_pkg::ACC_WRITE);
      brk_pkg::TYPE_RW:    type_ok = (kind == brk_pkg::ACC_READ) ||
                                     (kind == brk_pkg::ACC_WRITE);
      default:             type_ok = 1'b0;
    endcase
  endfunction

  // overlap of the aligned breakpoint range with the accessed byte range
  function automatic logic range_hit(input logic [31:0] bp,
                                     input logic [1:0]  bp_len,
                                     input logic [31:0] addr,
                                     input logic [1:0]  addr_len);
    logic [1:0]  bspan;
    logic [31:0] base;
    logic [32:0] bend;
    logic [32:0] aend;
    bspan = len_span(bp_len);
    base  = bp & ~{30'h0, bspan};
    bend  = {1'b0, base} + {31'h0, bspan};
    aend  = {1'b0, addr} + {31'h0, len_span(addr_len)};
    range_hit = ({1'b0, addr} <= bend) && ({1'b0, base} <= aend);
  endfunction

  // access-type field of one breakpoint
  function automatic logic [1:0] type_field(input logic [31:0] ctl,
                                            input int          idx);
    type_field = ctl[brk_pkg::CTL_FIELD_LSB + idx*brk_pkg::CTL_FIELD_W
                     +: brk_pkg::CTL_SUB_W]; // RULE_06
  endfunction

  // length field of one breakpoint, above its access-type field
  function automatic logic [1:0] len_field(input logic [31:0] ctl,
                                           input int          idx);
    len_field = ctl[brk_pkg::CTL_FIELD_LSB + idx*brk_pkg::CTL_FIELD_W
                    + brk_pkg::CTL_LEN_OFS +: brk_pkg::CTL_SUB_W]; // RULE_06
  endfunction

  // bit position of a local enable; the global enable sits just above
  function automatic int local_bit(input int idx);
    local_bit = idx*brk_pkg::CTL_EN_W;
  endfunction

  // breakpoint is armed by either its local or its global enable
  function automatic logic armed_bp(input logic [31:0] ctl,
                                    input int          idx);
    armed_bp = ctl[local_bit(idx)]
               || ctl[local_bit(idx) + brk_pkg::CTL_G_OFS]; // RULE_05
  endfunction

  // full match condition of one breakpoint, enables not considered
  function automatic logic cond_of(input state_t             s,
                                   input int                 idx,
                                   input logic               valid,
                                   input brk_pkg::acc_kind_t kind,
                                   input logic [31:0]        addr,
                                   input logic [1:0]         len);
    cond_of = valid && type_ok(type_field(s.ctl, idx), kind) // RULE_07 RULE_12
              && range_hit(s.bp_addr[idx], len_field(s.ctl, idx), addr,
                           len); // RULE_03 RULE_13 RULE_16
  endfunction

  // per-breakpoint conditions and enables
  logic [brk_pkg::NUM_BP-1:0] cond_hit;
  logic [brk_pkg::NUM_BP-1:0] armed;
  always_comb begin
    cond_hit = '0;
    armed    = '0;
    for (int i = 0; i < brk_pkg::NUM_BP; i++) begin
      cond_hit[i] = cond_of(cur, i, acc_valid_in, acc_kind_in, acc_addr_in, acc_len_in);
      armed[i]    = armed_bp(cur.ctl, i);
    end
  end

  // status image: fixed bits, event flags and match flags
  function automatic logic [31:0] status_image(input state_t s);
    status_image = brk_pkg::ST_FIXED_ONE; // RULE_10 RULE_11
    status_image[brk_pkg::ST_BT_BIT] = s.task_switch_flag;
    status_image[brk_pkg::ST_BS_BIT] = s.single_step_flag;
    status_image[brk_pkg::NUM_BP-1:0] = s.match_flag;
  endfunction

  // index selects one of the address registers
  function automatic logic is_addr_idx(input logic [2:0] idx);
    is_addr_idx = (idx <= brk_pkg::IDX_ADDR_LAST);
  endfunction

  // index selects the control register
  function automatic logic is_ctl_idx(input logic [2:0] idx);
    is_ctl_idx = (idx == brk_pkg::IDX_CONTROL);
  endfunction

  // control image after a write: fixed bits forced, reserved bits dropped
  function automatic logic [31:0] ctl_write_image(input logic [31:0] wdata);
    ctl_write_image = (wdata & brk_pkg::CTL_WRITABLE)
                      | brk_pkg::CTL_FIXED_ONE; // RULE_11
  endfunction

  // control image after a task switch: locals cleared, globals kept
  function automatic logic [31:0] drop_locals(input logic [31:0] ctl);
    drop_locals = ctl;
    for (int i = 0; i < brk_pkg::NUM_BP; i++) begin
      drop_locals[local_bit(i)] = 1'b0; // RULE_14
    end
  endfunction

  // level 0 or real mode may reach the debug registers
  function automatic logic priv_ok(input logic [1:0] level,
                                   input logic       real_mode);
    priv_ok = (level == brk_pkg::PRIV_TOP) || real_mode; // RULE_04
  endfunction

  // register read image
  function automatic logic [31:0] read_reg(input state_t s,
                                           input logic [2:0] idx);
    if (is_addr_idx(idx)) begin
      read_reg = s.bp_addr[idx[1:0]];
    end else if (idx == brk_pkg::IDX_STATUS) begin
      read_reg = status_image(s); // RULE_09
    end else if (is_ctl_idx(idx)) begin
      read_reg = s.ctl;
    end else begin
      read_reg = 32'h0000_0000;
    end
  endfunction

  // next-state logic
  always_comb begin
    logic allowed;
    logic gd_trap;
    logic granted;
    logic do_write;
    logic do_read;
    logic bp_exc;
    logic any_exc;
    logic [brk_pkg::NUM_BP-1:0] set_match;
    // start from the held state; only the changes follow
    next_cur = cur;
    allowed  = priv_ok(priv_level_in, real_mode_in); // RULE_04
    gd_trap  = reg_req_in && allowed && cur.ctl[brk_pkg::CTL_GD_BIT];
    granted  = reg_req_in && allowed && !gd_trap;
    do_write = granted && reg_write_in;
    do_read  = granted && !reg_write_in;
    bp_exc   = |(cond_hit & armed); // RULE_02
    // every cause of a debug exception in this cycle
    any_exc  = bp_exc
               || gd_trap
               || single_step_in
               || task_trap_in;
    set_match = any_exc ? cond_hit : '0; // RULE_15

    // register port answers one cycle after the request
    next_cur.ack   = reg_req_in;
    next_cur.fault = reg_req_in && !allowed; // RULE_04
    next_cur.trap  = gd_trap;
    if (do_read) begin
      next_cur.rdata = read_reg(cur, reg_index_in);
    end else begin
      next_cur.rdata = 32'h0000_0000;
    end

    // writes; the status register ignores them
    if (do_write) begin
      if (is_addr_idx(reg_index_in)) begin
        next_cur.bp_addr[reg_index_in[1:0]] = reg_wdata_in; // RULE_01
      end else if (is_ctl_idx(reg_index_in)) begin
        next_cur.ctl = ctl_write_image(reg_wdata_in); // RULE_11
      end
    end

    // task switch drops local enables, keeps global ones
    if (task_switch_in) begin
      next_cur.ctl = drop_locals(next_cur.ctl); // RULE_14
    end

    // any debug exception releases the access-disable bit
    if (any_exc) begin
      next_cur.ctl[brk_pkg::CTL_GD_BIT] = 1'b0; // RULE_14
    end

    // sticky status; a set in the clear cycle survives
    if (status_clear_in) begin
      next_cur.match_flag       = '0;
      next_cur.task_switch_flag = 1'b0;
      next_cur.single_step_flag = 1'b0;
    end
    next_cur.match_flag = next_cur.match_flag | set_match; // RULE_15
    if (task_trap_in) begin
      next_cur.task_switch_flag = 1'b1;
    end
    if (single_step_in) begin
      next_cur.single_step_flag = 1'b1;
    end

    // exception is flagged the cycle after the fetch address is seen
    next_cur.exc = any_exc; // RULE_08
  end

  // state register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cur.bp_addr          <= {brk_pkg::NUM_BP{brk_pkg::ADDR_RESET}};
      cur.ctl              <= brk_pkg::CTL_RESET;
      cur.match_flag       <= '0;
      cur.task_switch_flag <= 1'b0;
      cur.single_step_flag <= 1'b0;
      cur.rdata            <= 32'h0000_0000;
      cur.ack              <= 1'b0;
      cur.fault            <= 1'b0;
      cur.trap             <= 1'b0;
      cur.exc              <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from the state register
  assign reg_ack_out   = cur.ack;
  assign reg_fault_out = cur.fault;
  assign reg_trap_out  = cur.trap;
  assign reg_rdata_out = cur.rdata;
  assign debug_exc_out = cur.exc;

endmodule

// ---- sim/brk_sva.sv ----
/*
  port-level checks of the breakpoint unit: register-move answers,
  privilege refusal, fixed status bits and exception causes.
  assumes it is bound to breakpoint_debug_unit in the bench.
*/
`timescale 1ns/1ns
module brk_sva (
  // clock and reset
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  // register-move port
  input wire logic        reg_req_in,
  input wire logic        reg_write_in,
  input wire logic [2:0]  reg_index_in,
  input wire logic [1:0]  priv_level_in,
  input wire logic        real_mode_in,
  input wire logic        reg_ack_out,
  input wire logic        reg_fault_out,
  input wire logic        reg_trap_out,
  input wire logic [31:0] reg_rdata_out,
  // accesses and events
  input wire logic        acc_valid_in,
  input wire logic        task_trap_in,
  input wire logic        single_step_in,
  input wire logic        debug_exc_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // single-step and task-switch trap events that must raise an exception next cycle
  sequence step_ev;
    single_step_in || task_trap_in;
  endsequence
  // read of an unmapped index at top privilege
  sequence odd_rd;
    reg_req_in && !reg_write_in && reg_index_in == 3'h4 && priv_level_in == 2'h0;
  endsequence
  ack_after_req_a: assert property (reg_req_in |=> reg_ack_out)
    else $error("no ack after request");
  ack_has_req_a: assert property (reg_ack_out |-> $past(reg_req_in))
    else $error("ack without request");
  priv_fault_a: assert property (reg_req_in && priv_level_in != 2'h0 && !real_mode_in
    |=> reg_fault_out && reg_rdata_out == 32'h0) else $error("low privilege not refused");
  priv_pass_a: assert property (reg_req_in && real_mode_in |=> !reg_fault_out)
    else $error("real mode refused");
  status_fixed_a: assert property (reg_req_in && !reg_write_in && reg_index_in == 3'h6
    && priv_level_in == 2'h0 |=> reg_trap_out || (reg_rdata_out & 32'hFFFF_3FF0) == 32'h1FF0)
    else $error("status fixed bits wrong");
  unmapped_zero_a: assert property (odd_rd |=> reg_rdata_out == 32'h0)
    else $error("unmapped read not zero");
  trap_exc_a: assert property (reg_trap_out |-> debug_exc_out)
    else $error("access trap without exception");
  step_exc_a: assert property (step_ev |=> debug_exc_out)
    else $error("step event without exception");
  exc_cause_a: assert property (debug_exc_out |->
    $past(acc_valid_in || single_step_in || task_trap_in || reg_req_in))
    else $error("exception without cause");
endmodule

// ---- sim/core_model.sv ----
/*
  core pipeline stand-in: presents one access for one cycle, waits one
  more cycle for the exception output, then reports trapped or retired.
  assumes the unit answers one cycle after taking an access.
*/
`timescale 1ns/1ns
module core_model (
  // clock and reset
  input  wire logic               sys_clk_in,
  input  wire logic               rst_in,
  // request from the bench and exception from the unit
  input  wire logic               go_in,
  input  wire brk_pkg::acc_kind_t kind_in,
  input  wire logic [31:0]        addr_in,
  input  wire logic [1:0]         len_in,
  input  wire logic               exc_in,
  // access toward the unit
  output logic                    acc_valid_out,
  output brk_pkg::acc_kind_t      acc_kind_out,
  output logic [31:0]             acc_addr_out,
  output logic [1:0]              acc_len_out,
  // outcome
  output logic                    done_out,
  output logic                    trapped_out
);
  logic       stage;
  // present for one cycle, wait one cycle, then judge from the exception
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage         <= 1'b0;
      acc_valid_out <= 1'b0;
      acc_kind_out  <= brk_pkg::ACC_EXEC;
      acc_addr_out  <= 32'h0;
      acc_len_out   <= 2'h0;
      done_out      <= 1'b0;
      trapped_out   <= 1'b0;
    end else begin
      acc_valid_out <= go_in;
      done_out      <= 1'b0;
      stage         <= acc_valid_out;
      if (go_in) begin
        acc_kind_out <= kind_in;
        acc_addr_out <= addr_in;
        acc_len_out  <= len_in;
      end else begin
        acc_addr_out <= ~acc_addr_out;  // idle address lines keep no value
      end
      if (stage) begin
        done_out    <= 1'b1;
        trapped_out <= exc_in;
      end
    end
  end
endmodule

// ---- sim/tb.sv ----
/*
  bench of the breakpoint unit: register-move calls and accesses
  through the core stand-in, each followed by its expected outcome.
  assumes the package, the unit, the stand-in and the checker compile first.
*/
`timescale 1ns/1ns
module tb;
  typedef struct {logic [31:0] c; brk_pkg::acc_kind_t k; logic [31:0] a;
                  logic [1:0] l; int b; logic h;} case_t;
  logic               sys_clk_in, reg_ack_out, reg_fault_out, reg_trap_out, acc_valid_in;
  logic               debug_exc_out, done, trapped, rst_in = 1, go = 0;
  logic               reg_req_in = 0, reg_write_in = 0, real_mode_in = 0;
  logic [1:0]         priv_level_in = 0, len = 0, acc_len_in;
  logic [2:0]         reg_index_in = 0;
  logic [3:0]         evt = 0;
  logic [31:0]        reg_wdata_in = 0, addr = 0, reg_rdata_out, acc_addr_in;
  brk_pkg::acc_kind_t kind = brk_pkg::ACC_EXEC, acc_kind_in;
  int                 num_errors = 0, checks = 0, i;
  case_t              cases [8] = '{
    '{32'h0000_0001, brk_pkg::ACC_EXEC, 32'h100, 2'h0, 0, 1},
    '{32'h0000_0001, brk_pkg::ACC_EXEC, 32'h101, 2'h0, 0, 0},
    '{32'h0050_0008, brk_pkg::ACC_WRITE, 32'h201, 2'h0, 1, 1},
    '{32'h0050_0008, brk_pkg::ACC_READ, 32'h200, 2'h0, 1, 0},
    '{32'h0F00_0010, brk_pkg::ACC_READ, 32'h303, 2'h0, 2, 1},
    '{32'h0F00_0010, brk_pkg::ACC_WRITE, 32'h2FE, 2'h3, 2, 1},
    '{32'h0000_0000, brk_pkg::ACC_EXEC, 32'h400, 2'h0, 3, 0},
    '{32'h2000_0080, brk_pkg::ACC_READ, 32'h400, 2'h0, 3, 0}};
  breakpoint_debug_unit dut (.sys_clk_in, .rst_in, .reg_req_in, .reg_write_in, .reg_index_in,
    .reg_wdata_in, .priv_level_in, .real_mode_in, .reg_ack_out, .reg_fault_out, .reg_trap_out,
    .reg_rdata_out, .acc_valid_in, .acc_kind_in, .acc_addr_in, .acc_len_in,
    .task_switch_in(evt[0]), .task_trap_in(evt[1]), .single_step_in(evt[2]),
    .status_clear_in(evt[3]), .debug_exc_out);
  core_model core (.sys_clk_in, .rst_in, .go_in(go), .kind_in(kind), .addr_in(addr),
    .len_in(len), .exc_in(debug_exc_out), .acc_valid_out(acc_valid_in),
    .acc_kind_out(acc_kind_in), .acc_addr_out(acc_addr_in), .acc_len_out(acc_len_in),
    .done_out(done), .trapped_out(trapped));
  // compare, register move, event pulse and access helpers
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic mv(input logic w, input logic [2:0] x, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_req_in   <= 1'b1;
    reg_write_in <= w;
    reg_index_in <= x;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_req_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] x, input logic [31:0] e);
    mv(1'b0, x, 32'h0);
    chk("ack", 32'h1, 32'(reg_ack_out));
    chk("rdata", e, reg_rdata_out);
  endtask
  task automatic ev(input logic [3:0] v);
    @(posedge sys_clk_in) evt <= v;
    @(posedge sys_clk_in) evt <= 4'h0;
    #1;
  endtask
  task automatic run(input int n);
    @(posedge sys_clk_in);
    go   <= 1'b1;
    kind <= cases[n].k;
    addr <= cases[n].a;
    len  <= cases[n].l;
    @(posedge sys_clk_in) go <= 1'b0;
    for (int t = 0; t < 8 && !done; t++) begin
      @(posedge sys_clk_in);
      #1;
    end
    chk("done", 32'h1, 32'(done));
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // clock
  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  // watchdog
  initial begin
    #400000;
    num_errors++;
    close_out;
  end
  // test sequence
  initial begin
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    for (i = 0; i < 4; i++) rd(3'(i), 32'h0);
    rd(3'h7, 32'h0000_0400);
    rd(3'h6, 32'h0000_1FF0);
    for (i = 0; i < 4; i++) mv(1'b1, 3'(i), 32'h100 * (i + 1));
    for (i = 0; i < 4; i++) rd(3'(i), 32'h100 * (i + 1));
    mv(1'b1, 3'h6, 32'h0);
    rd(3'h6, 32'h0000_1FF0);
    rd(3'h4, 32'h0);
    mv(1'b1, 3'h7, 32'hFFFF_DFFF);
    rd(3'h7, 32'hFFFF_04FF);
    @(posedge sys_clk_in) priv_level_in <= 2'h3;
    mv(1'b1, 3'h0, 32'h0000_5A5A);
    chk("fault", 32'h1, 32'(reg_fault_out));
    @(posedge sys_clk_in) real_mode_in <= 1'b1;
    rd(3'h0, 32'h100);
    @(posedge sys_clk_in) priv_level_in <= 2'h0;
    for (i = 0; i < 8; i++) begin
      mv(1'b1, 3'h7, cases[i].c);
      run(i);
      chk("exception", 32'(cases[i].h), 32'(trapped));
      rd(3'h6, 32'h1FF0 | (32'(cases[i].h) << cases[i].b));
      ev(4'h8);
    end
    ev(4'hC);
    rd(3'h6, 32'h0000_5FF0);
    ev(4'h8);
    ev(4'h2);
    rd(3'h6, 32'h0000_9FF0);
    ev(4'h8);
    mv(1'b1, 3'h7, 32'h0000_00FF);
    ev(4'h1);
    rd(3'h7, 32'h0000_04AA);
    mv(1'b1, 3'h7, 32'h0000_2000);
    rd(3'h0, 32'h0);
    chk("trap", 32'h1, 32'(reg_trap_out));
    rd(3'h7, 32'h0000_0400);
    close_out;
  end
endmodule
bind breakpoint_debug_unit brk_sva chk_i (.sys_clk_in, .rst_in, .reg_req_in, .reg_write_in,
  .reg_index_in, .priv_level_in, .real_mode_in, .reg_ack_out, .reg_fault_out, .reg_trap_out,
  .reg_rdata_out, .acc_valid_in, .task_trap_in, .single_step_in, .debug_exc_out);
